// ===== verilog/port_switch_pkg.sv
// Shared constants and types of the port switch control block
package port_switch_pkg;
	// Two-wire slave address, upper five bits
	localparam logic [4:0] ADDR_FIXED = 5'h0b;
	// Pointer codes
	localparam logic [1:0] PTR_SINK_ONE = 2'h1;
	localparam logic [1:0] PTR_SINK_TWO = 2'h2;
	localparam logic [1:0] PTR_STATUS = 2'h3;
	// Power-up values
	localparam logic [7:0] PTR_RESET = 8'h03;
	localparam logic [7:0] SINK_ONE_RESET = 8'h08;
	localparam logic [7:0] SINK_TWO_RESET = 8'h09;
	localparam logic [7:0] STATUS_RESET = 8'h10;
	// Sink configuration field positions
	localparam int CFG_SEL_LO = 0;
	localparam int CFG_SEL_HI = 1;
	localparam int CFG_OUT_DIS = 2;
	localparam int CFG_DDC_EN = 3;
	localparam int CFG_DEEMPH = 4;
	// Status field positions
	localparam int ST_GATE_EN = 4;
	localparam int ST_PRIO = 5;
	// Bits per byte on the two-wire bus
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	// Data bytes accepted in one write: pointer, then data
	localparam logic [1:0] MAX_WR_BYTES = 2'h2;

	typedef enum logic [2:0] {
		SL_IDLE = 3'b000,
		SL_ADDR = 3'b001,
		SL_ACK = 3'b010,
		SL_RX = 3'b011,
		SL_TX = 3'b100,
		SL_RACK = 3'b101
	} slave_state_t;

	typedef struct packed {
		logic ptr_wr;
		logic data_wr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [1:0] tmds_sel;
		logic tmds_oe;
		logic [1:0] ddc_sel;
		logic ddc_oe;
		logic deemph;
	} sink_route_t;
endpackage

// ===== verilog/two_wire_sub_slave.sv
// Two-wire slave: address match, pointer and data byte writes, reads that repeat the register byte while the master acknowledges
`timescale 1ns/1ps
module two_wire_sub_slave (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [1:0] addr_pin,
	output logic sda_oe,
	// Register side
	input wire logic [7:0] rd_data,
	output port_switch_pkg::reg_req_t req
);
	typedef struct packed {
		port_switch_pkg::slave_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic [1:0] nbyte;
		logic mack;
		logic scl_q;
		logic sda_q;
		logic sda_oe;
		port_switch_pkg::reg_req_t req;
	} slave_regs_t;

	slave_regs_t q;
	slave_regs_t d;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic addr_hit;

	assign rise = !q.scl_q && scl_in;
	assign fall = q.scl_q && !scl_in;
	assign start = q.scl_q && scl_in && q.sda_q && !sda_in;
	assign stop = q.scl_q && scl_in && !q.sda_q && sda_in;
	assign addr_hit = q.sh[7:1] == {port_switch_pkg::ADDR_FIXED, addr_pin}; // see RULE_14
	assign sda_oe = q.sda_oe;
	assign req = q.req;

	always_comb begin
		d = q;
		d.req.ptr_wr = 1'b0;
		d.req.data_wr = 1'b0;
		d.scl_q = scl_in;
		d.sda_q = sda_in;
		if (start) begin
			d.st = port_switch_pkg::SL_ADDR;
			d.cnt = 4'h0;
			d.nbyte = 2'h0;
			d.sda_oe = 1'b0;
		end else if (stop) begin
			d.st = port_switch_pkg::SL_IDLE;
			d.sda_oe = 1'b0;
		end else begin
			case (q.st)
				port_switch_pkg::SL_IDLE: begin
					d.sda_oe = 1'b0;
				end
				port_switch_pkg::SL_ADDR: begin
					if (rise && q.cnt != port_switch_pkg::BYTE_BITS) begin
						d.sh = {q.sh[6:0], sda_in};
						d.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == port_switch_pkg::BYTE_BITS) begin
						if (addr_hit) begin // see RULE_14
							d.rw = q.sh[0];
							d.sda_oe = 1'b1;
							d.st = port_switch_pkg::SL_ACK;
						end else begin
							d.st = port_switch_pkg::SL_IDLE;
						end
					end
				end
				port_switch_pkg::SL_ACK: begin
					if (fall) begin
						d.cnt = 4'h0;
						if (q.rw) begin
							// Read returns the register under the pointer
							d.sh = rd_data; // see RULE_16
							d.sda_oe = !rd_data[7];
							d.st = port_switch_pkg::SL_TX;
						end else begin
							d.sda_oe = 1'b0;
							d.st = port_switch_pkg::SL_RX;
						end
					end
				end
				port_switch_pkg::SL_RX: begin
					if (rise && q.cnt != port_switch_pkg::BYTE_BITS) begin
						d.sh = {q.sh[6:0], sda_in};
						d.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == port_switch_pkg::BYTE_BITS) begin
						if (q.nbyte != port_switch_pkg::MAX_WR_BYTES) begin
							// First byte is the pointer, second the data
							d.req.ptr_wr = q.nbyte == 2'h0;
							d.req.data_wr = q.nbyte == 2'h1;
							d.req.wdata = q.sh;
							d.nbyte = q.nbyte + 2'h1;
							d.sda_oe = 1'b1;
							d.st = port_switch_pkg::SL_ACK;
						end else begin
							// Further bytes are left unacknowledged
							d.st = port_switch_pkg::SL_IDLE; // see RULE_15
						end
					end
				end
				port_switch_pkg::SL_TX: begin
					if (fall) begin
						if (q.cnt == port_switch_pkg::LAST_TX_BIT) begin
							d.sda_oe = 1'b0;
							d.st = port_switch_pkg::SL_RACK;
						end else begin
							d.sh = {q.sh[6:0], 1'b0};
							d.sda_oe = !q.sh[6];
							d.cnt = q.cnt + 4'h1;
						end
					end
				end
				port_switch_pkg::SL_RACK: begin
					if (rise) begin
						d.mack = !sda_in;
					end else if (fall) begin
						d.cnt = 4'h0;
						if (q.mack) begin
							d.sh = rd_data; // see RULE_16
							d.sda_oe = !rd_data[7];
							d.st = port_switch_pkg::SL_TX;
						end else begin
							d.st = port_switch_pkg::SL_IDLE;
						end
					end
				end
				default: begin
					d.st = port_switch_pkg::SL_IDLE;
					d.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.scl_q <= 1'b1;
			q.sda_q <= 1'b1;
		end else begin
			q <= d;
		end
	end

	chk_addr_ack: // see RULE_14
	assert property (@(posedge clk) disable iff (!resetn)
		(q.st == port_switch_pkg::SL_ADDR && fall && !start && !stop
			&& q.cnt == port_switch_pkg::BYTE_BITS && addr_hit)
		|=> q.sda_oe && q.st == port_switch_pkg::SL_ACK)
		else $error("address match not acknowledged");

	chk_third_nack: // see RULE_15
	assert property (@(posedge clk) disable iff (!resetn)
		(q.st == port_switch_pkg::SL_RX && fall && !start && !stop
			&& q.cnt == port_switch_pkg::BYTE_BITS && q.nbyte == 2'h2)
		|=> !q.sda_oe && !q.req.data_wr && !q.req.ptr_wr)
		else $error("extra write byte was accepted");

	chk_read_load: // see RULE_16
	assert property (@(posedge clk) disable iff (!resetn)
		(q.st == port_switch_pkg::SL_ACK && fall && q.rw && !start && !stop)
		|=> q.sh == $past(rd_data) && q.st == port_switch_pkg::SL_TX)
		else $error("read byte not loaded from register");
endmodule

// ===== verilog/dual_sink_port_select_ctrl.sv
// Register bank and routing control of the four-source two-sink port switch
// Functional notes
// RULE_01: Select bits pick source; hot-plug follows selection
// RULE_02: Output disable and DDC enable act independently
// RULE_03: Hot-plug forwarding continues while outputs disabled
// RULE_04: Shared source: priority picks DDC and hot-plug
// RULE_05: Gated low supply: outputs off, hot-plug low
// RULE_06: Without gating, supply indicator is ignored
// RULE_07: Pointer low bits pick register, upper zero
// RULE_08: Pointer powers up selecting status register
// RULE_09: Sink one configuration field layout
// RULE_10: Sink one powers up at 0x08
// RULE_11: Sink two uses same layout independently
// RULE_12: Sink two powers up at 0x09
// RULE_13: Status layout: priority, gating, supply indicators
// RULE_14: Slave address 01011 plus two pins
// RULE_15: One data byte per write transfer
// RULE_16: Read returns selected register as one byte
// RULE_17: Status powers up with gating enabled
// RULE_18: De-emphasis bit selects de-emphasised drive
// RULE_19: Supply bits live, read-only; reserved read zero
`timescale 1ns/1ps
module dual_sink_port_select_ctrl (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Two-wire register port
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [1:0] ADDR_PIN,
	// Source side status and hot-plug
	input wire logic [3:0] SOURCE_SUPPLY_SEEN,
	input wire logic GLOBAL_POWER_GATE,
	output logic [3:0] SOURCE_HOTPLUG_OUT,
	// Sink side
	input wire logic [1:0] SINK_HOTPLUG_IN,
	output port_switch_pkg::sink_route_t SINK_ONE_ROUTE,
	output port_switch_pkg::sink_route_t SINK_TWO_ROUTE
);
	typedef struct packed {
		logic [1:0] ptr;
		logic [1:0][4:0] cfg;
		logic prio;
		logic gate_en;
		logic [3:0] hpd;
		port_switch_pkg::sink_route_t [1:0] route;
		logic sda_level;
	} ctl_regs_t;

	ctl_regs_t q;
	ctl_regs_t d;
	port_switch_pkg::reg_req_t req;
	logic [7:0] rd_byte;
	logic gate_on;
	logic shared;
	logic conflict;
	logic [1:0] pwr_ok;
	logic [1:0] ddc_loser;
	logic [1:0] hpd_src;
	logic [1:0][1:0] sel;

	two_wire_sub_slave two_wire_sub_slave_inst (
		.clk(CLK_SYS),
		.resetn(RESETN),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.addr_pin(ADDR_PIN),
		.sda_oe(SDA_OE),
		.rd_data(rd_byte),
		.req(req)
	);

	// Gating applies from the pin or from the register bit
	assign gate_on = GLOBAL_POWER_GATE || q.gate_en; // see RULE_05
	assign shared = sel[0] == sel[1];
	assign conflict = shared
		&& !q.cfg[0][port_switch_pkg::CFG_OUT_DIS] && !q.cfg[1][port_switch_pkg::CFG_OUT_DIS]
		&& q.cfg[0][port_switch_pkg::CFG_DDC_EN] && q.cfg[1][port_switch_pkg::CFG_DDC_EN];

	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : g_sink
			logic loses;
			assign sel[s] = {q.cfg[s][port_switch_pkg::CFG_SEL_HI],
				q.cfg[s][port_switch_pkg::CFG_SEL_LO]}; // see RULE_01
			// Low priority hands the shared source to sink one, high to sink two
			assign loses = (s == 0) ? q.prio : !q.prio; // see RULE_04
			// Indicator only counts while gating applies
			assign pwr_ok[s] = !gate_on || SOURCE_SUPPLY_SEEN[sel[s]]; // see RULE_05 RULE_06
			assign ddc_loser[s] = conflict && loses; // see RULE_04
			// Hot-plug ignores output and DDC enables
			assign hpd_src[s] = pwr_ok[s] && SINK_HOTPLUG_IN[s]
				&& !(shared && loses); // see RULE_03 RULE_04
		end
	endgenerate

	// Read view of the register under the pointer
	always_comb begin
		case (q.ptr)
			port_switch_pkg::PTR_SINK_ONE: rd_byte = {3'h0, q.cfg[0]}; // see RULE_09
			port_switch_pkg::PTR_SINK_TWO: rd_byte = {3'h0, q.cfg[1]}; // see RULE_11
			port_switch_pkg::PTR_STATUS: rd_byte = {2'h0, q.prio, q.gate_en,
				SOURCE_SUPPLY_SEEN}; // see RULE_13 RULE_19
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		d = q;
		d.sda_level = 1'b0;
		if (req.ptr_wr) begin
			d.ptr = req.wdata[1:0]; // see RULE_07
		end
		if (req.data_wr) begin
			case (q.ptr)
				port_switch_pkg::PTR_SINK_ONE: d.cfg[0] = req.wdata[4:0]; // see RULE_09
				port_switch_pkg::PTR_SINK_TWO: d.cfg[1] = req.wdata[4:0]; // see RULE_11
				port_switch_pkg::PTR_STATUS: begin
					// Supply indicators are inputs, so writes to them drop
					d.prio = req.wdata[port_switch_pkg::ST_PRIO]; // see RULE_13 RULE_19
					d.gate_en = req.wdata[port_switch_pkg::ST_GATE_EN];
				end
				default: d.ptr = q.ptr;
			endcase
		end
		for (int k = 0; k < 2; k++) begin
			d.route[k].tmds_sel = sel[k]; // see RULE_01
			d.route[k].ddc_sel = sel[k];
			d.route[k].tmds_oe = !q.cfg[k][port_switch_pkg::CFG_OUT_DIS]
				&& pwr_ok[k]; // see RULE_02 RULE_05
			d.route[k].ddc_oe = q.cfg[k][port_switch_pkg::CFG_DDC_EN]
				&& pwr_ok[k] && !ddc_loser[k]; // see RULE_02 RULE_04
			d.route[k].deemph = q.cfg[k][port_switch_pkg::CFG_DEEMPH]; // see RULE_18
		end
		for (int k = 0; k < 4; k++) begin
			d.hpd[k] = (sel[0] == k[1:0] && hpd_src[0])
				|| (sel[1] == k[1:0] && hpd_src[1]); // see RULE_01
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			q <= '0;
			q.ptr <= port_switch_pkg::PTR_RESET[1:0]; // see RULE_08
			q.cfg[0] <= port_switch_pkg::SINK_ONE_RESET[4:0]; // see RULE_10
			q.cfg[1] <= port_switch_pkg::SINK_TWO_RESET[4:0]; // see RULE_12
			q.prio <= port_switch_pkg::STATUS_RESET[port_switch_pkg::ST_PRIO]; // see RULE_17
			q.gate_en <= port_switch_pkg::STATUS_RESET[port_switch_pkg::ST_GATE_EN];
		end else begin
			q <= d;
		end
	end

	assign SDA_OUT = q.sda_level;
	assign SOURCE_HOTPLUG_OUT = q.hpd;
	assign SINK_ONE_ROUTE = q.route[0];
	assign SINK_TWO_ROUTE = q.route[1];

	chk_sel_route: // see RULE_01
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$past(RESETN) |-> SINK_TWO_ROUTE.tmds_sel == $past(sel[1])
			&& SINK_TWO_ROUTE.ddc_sel == $past(sel[1]))
		else $error("sink two route does not follow select bits");

	chk_disable_tmds: // see RULE_02
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		q.cfg[0][port_switch_pkg::CFG_OUT_DIS] |=> !SINK_ONE_ROUTE.tmds_oe)
		else $error("disabled sink one still drives");

	chk_ddc_off: // see RULE_02
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!q.cfg[1][port_switch_pkg::CFG_DDC_EN] && !gate_on && !q.cfg[1][port_switch_pkg::CFG_OUT_DIS])
		|=> !SINK_TWO_ROUTE.ddc_oe && SINK_TWO_ROUTE.tmds_oe)
		else $error("sink two DDC enable not independent");

	chk_hpd_follow: // see RULE_03
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(q.cfg[0][port_switch_pkg::CFG_OUT_DIS] && !gate_on && !shared)
		|=> SOURCE_HOTPLUG_OUT[$past(sel[0])] == $past(SINK_HOTPLUG_IN[0]))
		else $error("hot-plug not forwarded while disabled");

	chk_prio_low: // see RULE_04
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(conflict && sel[0] == 2'h0 && !q.prio && !gate_on)
		|=> !SINK_TWO_ROUTE.ddc_oe && SINK_ONE_ROUTE.ddc_oe
			&& SOURCE_HOTPLUG_OUT[0] == $past(SINK_HOTPLUG_IN[0]))
		else $error("low priority sharing wrong");

	chk_gate_hpd: // see RULE_05
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(gate_on && !SOURCE_SUPPLY_SEEN[sel[0]] && !SOURCE_SUPPLY_SEEN[sel[1]])
		|=> SOURCE_HOTPLUG_OUT == 4'h0 && !SINK_ONE_ROUTE.tmds_oe && !SINK_TWO_ROUTE.ddc_oe)
		else $error("gated unpowered source still routed");

	chk_no_gate: // see RULE_06
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!GLOBAL_POWER_GATE && !q.gate_en && !q.cfg[0][port_switch_pkg::CFG_OUT_DIS])
		|=> SINK_ONE_ROUTE.tmds_oe)
		else $error("supply indicator used without gating");

	chk_ptr_write: // see RULE_07
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		req.ptr_wr |=> q.ptr == $past(req.wdata[1:0]))
		else $error("pointer write lost");

	chk_cfg_write: // see RULE_11
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(req.data_wr && q.ptr == port_switch_pkg::PTR_SINK_TWO)
		|=> q.cfg[1] == $past(req.wdata[4:0]) && q.cfg[0] == $past(q.cfg[0]))
		else $error("sink two write wrong");

	chk_status_read: // see RULE_19
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		q.ptr == port_switch_pkg::PTR_STATUS
		|-> rd_byte[3:0] == SOURCE_SUPPLY_SEEN && rd_byte[7:6] == 2'h0)
		else $error("status read wrong");

	chk_reset_vals: // see RULE_08
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!$past(RESETN) |-> q.ptr == port_switch_pkg::PTR_RESET[1:0]
			&& q.cfg[0] == port_switch_pkg::SINK_ONE_RESET[4:0]
			&& q.cfg[1] == port_switch_pkg::SINK_TWO_RESET[4:0]
			&& q.gate_en && !q.prio)
		else $error("power-up values wrong");

	chk_sel_one: // see RULE_01
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$past(RESETN) |-> SINK_ONE_ROUTE.tmds_sel == $past(sel[0])
			&& SINK_ONE_ROUTE.ddc_sel == $past(sel[0]))
		else $error("sink one route does not follow select bits");

	chk_hpd_unsel: // see RULE_01
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		($past(RESETN) && $past(sel[0]) != 2'h3 && $past(sel[1]) != 2'h3)
		|-> !SOURCE_HOTPLUG_OUT[3])
		else $error("unselected source hot-plug not low");

	chk_disable_two: // see RULE_02
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		q.cfg[1][port_switch_pkg::CFG_OUT_DIS] |=> !SINK_TWO_ROUTE.tmds_oe)
		else $error("disabled sink two still drives");

	chk_ddc_one_off: // see RULE_02
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!q.cfg[0][port_switch_pkg::CFG_DDC_EN] |=> !SINK_ONE_ROUTE.ddc_oe)
		else $error("sink one DDC still connected");

	chk_prio_high: // see RULE_04
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(conflict && sel[0] == 2'h0 && q.prio && !gate_on)
		|=> !SINK_ONE_ROUTE.ddc_oe && SINK_TWO_ROUTE.ddc_oe
			&& SOURCE_HOTPLUG_OUT[0] == $past(SINK_HOTPLUG_IN[1]))
		else $error("high priority sharing wrong");

	chk_gate_two: // see RULE_05
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(gate_on && !SOURCE_SUPPLY_SEEN[sel[1]])
		|=> !SINK_TWO_ROUTE.tmds_oe && !SINK_TWO_ROUTE.ddc_oe)
		else $error("sink two routed from unpowered source");

	chk_gate_hpd_one: // see RULE_05
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(gate_on && !SOURCE_SUPPLY_SEEN[sel[0]] && !shared)
		|=> !SOURCE_HOTPLUG_OUT[$past(sel[0])])
		else $error("unpowered source hot-plug not low");

	chk_no_gate_two: // see RULE_06
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!GLOBAL_POWER_GATE && !q.gate_en && !q.cfg[1][port_switch_pkg::CFG_OUT_DIS])
		|=> SINK_TWO_ROUTE.tmds_oe)
		else $error("sink two gated without gating");

	chk_ptr_hold: // see RULE_07
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!req.ptr_wr |=> q.ptr == $past(q.ptr))
		else $error("pointer changed without write");

	chk_cfg_one_write: // see RULE_09
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(req.data_wr && q.ptr == port_switch_pkg::PTR_SINK_ONE)
		|=> q.cfg[0] == $past(req.wdata[4:0]) && q.cfg[1] == $past(q.cfg[1]))
		else $error("sink one write wrong");

	chk_cfg_read: // see RULE_09
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		q.ptr == port_switch_pkg::PTR_SINK_ONE
		|-> rd_byte[7:5] == 3'h0 && rd_byte[4:0] == q.cfg[0])
		else $error("sink one read wrong");

	chk_null_read: // see RULE_07
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		q.ptr == 2'h0 |-> rd_byte == 8'h00)
		else $error("unused pointer code reads non-zero");

	chk_status_write: // see RULE_13
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(req.data_wr && q.ptr == port_switch_pkg::PTR_STATUS)
		|=> q.prio == $past(req.wdata[port_switch_pkg::ST_PRIO])
			&& q.gate_en == $past(req.wdata[port_switch_pkg::ST_GATE_EN]))
		else $error("status write wrong");

	chk_deemph_follow: // see RULE_18
	assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$past(RESETN) |-> SINK_ONE_ROUTE.deemph == $past(q.cfg[0][port_switch_pkg::CFG_DEEMPH])
			&& SINK_TWO_ROUTE.deemph == $past(q.cfg[1][port_switch_pkg::CFG_DEEMPH]))
		else $error("de-emphasis does not follow its bit");
endmodule

// ===== test/host_master_model.sv
// Two-wire bus master model standing in for the host
`timescale 1ns/1ps
module host_master_model (
	// Clock
	input wire logic clk,
	// Bus pins
	input wire logic sda_wire,
	input wire logic [6:0] dev_addr,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data changes only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda <= b;
		hold(4);
		scl <= 1'b1;
		hold(4);
		r = sda_wire;
		scl <= 1'b0;
		hold(2);
	endtask

	task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ai, a);
	endtask

	task automatic start();
		sda <= 1'b1;
		scl <= 1'b1;
		hold(4);
		sda <= 1'b0;
		hold(4);
		scl <= 1'b0;
		hold(4);
	endtask

	task automatic stop();
		sda <= 1'b0;
		hold(2);
		scl <= 1'b1;
		hold(4);
		sda <= 1'b1;
		hold(4);
	endtask

	// Pointer byte, then at most one data byte per transfer
	task automatic write_reg(input logic [7:0] p, input logic [7:0] d, input logic wd,
		output logic ok);
		logic [7:0] rx;
		logic a0;
		logic a1;
		logic a2;
		start();
		xfer({dev_addr, 1'b0}, 1'b1, rx, a0);
		xfer(p, 1'b1, rx, a1);
		a2 = 1'b0;
		if (wd) begin
			xfer(d, 1'b1, rx, a2);
		end
		stop();
		ok = !(a0 | a1 | a2);
	endtask

	// Two data bytes in one transfer; the second must be refused
	task automatic write_over(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1,
		output logic refused);
		logic [7:0] rx;
		logic a0;
		logic a1;
		logic a2;
		logic a3;
		start();
		xfer({dev_addr, 1'b0}, 1'b1, rx, a0);
		xfer(p, 1'b1, rx, a1);
		xfer(d0, 1'b1, rx, a2);
		xfer(d1, 1'b1, rx, a3);
		stop();
		refused = !(a0 | a1 | a2) && a3;
	endtask

	// Single byte read closed by a not-acknowledge
	task automatic read_reg(output logic [7:0] d, output logic ok);
		logic [7:0] rx;
		logic a0;
		logic a1;
		start();
		xfer({dev_addr, 1'b1}, 1'b1, rx, a0);
		xfer(8'hff, 1'b1, d, a1);
		stop();
		ok = !a0;
	endtask
endmodule

// ===== test/dual_sink_port_select_ctrl_tb_top.sv
// Self-checking bench for the port switch control block
`timescale 1ns/1ps
module dual_sink_port_select_ctrl_tb_top;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic scl;
	logic sda_m;
	logic sda_out;
	logic sda_oe;
	logic gate = 1'b0;
	logic [1:0] addr_pin = 2'h0;
	logic [1:0] hp_in = 2'h3;
	logic [3:0] supply = 4'hf;
	logic [3:0] hp_out;
	logic [6:0] dev_addr = {port_switch_pkg::ADDR_FIXED, 2'h0};
	port_switch_pkg::sink_route_t r1;
	port_switch_pkg::sink_route_t r2;
	int num_errors = 0;
	int n_tests = 0;
	// Pulled-up bus line
	wire sda_wire = sda_m & ~sda_oe;

	dual_sink_port_select_ctrl dual_sink_port_select_ctrl_inst (
		.CLK_SYS(clk_sys), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_wire),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_PIN(addr_pin),
		.SOURCE_SUPPLY_SEEN(supply), .GLOBAL_POWER_GATE(gate),
		.SOURCE_HOTPLUG_OUT(hp_out), .SINK_HOTPLUG_IN(hp_in),
		.SINK_ONE_ROUTE(r1), .SINK_TWO_ROUTE(r2)
	);

	host_master_model host_master_model_inst (
		.clk(clk_sys), .sda_wire(sda_wire), .dev_addr(dev_addr), .scl(scl), .sda(sda_m)
	);

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (num_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	function automatic logic [7:0] rt(input logic [1:0] s, input logic t, d, e);
		return {1'b0, s, t, s, d, e};
	endfunction

	task automatic settle();
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		host_master_model_inst.write_reg(p, d, 1'b1, ok);
		check({7'h0, ok}, 8'h01);
		settle();
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] exp);
		logic ok;
		logic [7:0] d;
		host_master_model_inst.write_reg(p, 8'h00, 1'b0, ok);
		host_master_model_inst.read_reg(d, ok);
		check(d, exp);
	endtask

	task automatic t_reset();
		logic ok;
		logic [7:0] d;
		check({1'b0, r1}, rt(2'h0, 1'b1, 1'b1, 1'b0));
		check({1'b0, r2}, rt(2'h1, 1'b1, 1'b1, 1'b0));
		check({4'h0, hp_out}, 8'h03);
		check({7'h0, sda_out}, 8'h00);
		host_master_model_inst.read_reg(d, ok);
		check(d, 8'h1f);
		rd(8'h01, port_switch_pkg::SINK_ONE_RESET);
		rd(8'h02, port_switch_pkg::SINK_TWO_RESET);
	endtask

	task automatic t_select();
		hp_in <= 2'h1;
		wr(8'h03, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(8'h01, 8'h08 | 8'(s));
			check({1'b0, r1}, rt(2'(s), 1'b1, 1'b1, 1'b0));
			check({4'h0, hp_out}, 8'h01 << s);
		end
		wr(8'h02, 8'h0a);
		check({1'b0, r2}, rt(2'h2, 1'b1, 1'b1, 1'b0));
		check({1'b0, r1}, rt(2'h3, 1'b1, 1'b1, 1'b0));
	endtask

	task automatic t_enable();
		wr(8'h01, 8'h07);
		check({1'b0, r1}, rt(2'h3, 1'b0, 1'b0, 1'b0));
		check({4'h0, hp_out}, 8'h08);
		wr(8'h02, 8'h02);
		check({1'b0, r2}, rt(2'h2, 1'b1, 1'b0, 1'b0));
		wr(8'h01, 8'h0f);
		check({1'b0, r1}, rt(2'h3, 1'b0, 1'b1, 1'b0));
		wr(8'h01, 8'h1b);
		check({1'b0, r1}, rt(2'h3, 1'b1, 1'b1, 1'b1));
		wr(8'h01, 8'hff);
		rd(8'h01, 8'h1f);
	endtask

	task automatic t_prio();
		hp_in <= 2'h2;
		wr(8'h01, 8'h08);
		wr(8'h02, 8'h08);
		check({1'b0, r2}, rt(2'h0, 1'b1, 1'b0, 1'b0));
		check({4'h0, hp_out}, 8'h00);
		wr(8'h03, 8'h20);
		check({1'b0, r1}, rt(2'h0, 1'b1, 1'b0, 1'b0));
		check({1'b0, r2}, rt(2'h0, 1'b1, 1'b1, 1'b0));
		check({4'h0, hp_out}, 8'h01);
	endtask

	task automatic t_gate();
		hp_in <= 2'h3;
		supply <= 4'he;
		wr(8'h02, 8'h09);
		wr(8'h03, 8'h10);
		check({1'b0, r1}, rt(2'h0, 1'b0, 1'b0, 1'b0));
		check({4'h0, hp_out}, 8'h02);
		supply <= 4'hc;
		settle();
		check({4'h0, hp_out}, 8'h00);
		check({1'b0, r2}, rt(2'h1, 1'b0, 1'b0, 1'b0));
		supply <= 4'he;
		wr(8'h03, 8'h00);
		check({1'b0, r1}, rt(2'h0, 1'b1, 1'b1, 1'b0));
		gate <= 1'b1;
		settle();
		check({1'b0, r1}, rt(2'h0, 1'b0, 1'b0, 1'b0));
		gate <= 1'b0;
		wr(8'h03, 8'hff);
		rd(8'h03, 8'h3e);
		supply <= 4'h5;
		rd(8'h03, 8'h35);
	endtask

	task automatic t_addr();
		logic ok;
		addr_pin <= 2'h2;
		dev_addr <= {port_switch_pkg::ADDR_FIXED, 2'h2};
		rd(8'hfe, 8'h09);
		host_master_model_inst.write_over(8'h02, 8'h0f, 8'h00, ok);
		check({7'h0, ok}, 8'h01);
		rd(8'h02, 8'h0f);
		rd(8'h04, 8'h00);
		dev_addr <= {port_switch_pkg::ADDR_FIXED, 2'h1};
		host_master_model_inst.write_reg(8'h01, 8'h00, 1'b1, ok);
		check({7'h0, ok}, 8'h00);
	endtask

	initial begin
		// All scenarios take about ten thousand cycles
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		settle();
		t_reset();
		t_select();
		t_enable();
		t_prio();
		t_gate();
		t_addr();
		wrap_up();
	end
endmodule
